/* aic_core.sv */
// Input selection, coding and track timing of a dual sampling converter
// Assumes pins from a host on asynchronous timing; clk_i much faster than sclk
`timescale 1ns/10ps
`include "aic_map.svh"
module aic_core #(
	parameter int ADDR_W = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Host pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic input_type_select_i,
	input wire logic [ADDR_W-1:0] channel_address_bits_i,
	input wire logic range_i,
	// Live selection for the multiplexers
	output aic_pkg::aic_cfg_t live_cfg_o,
	// Captured set of the running conversion
	output aic_pkg::aic_cfg_t conv_cfg_o,
	output logic converting_o,
	output logic tracking_o,
	output logic conv_start_o,
	output logic acq_restart_o,
	output logic conv_done_o
);
	// Decoder is written for exactly three address bits
	if (ADDR_W != `AIC_ADDR_W) begin : g_addr_check
		$error("aic_core: channel address width must be three bits");
	end

	// Synchronised pins
	logic [6:0] pins;
	logic cs_n_s;
	logic sclk_s;
	logic sgl_s;
	logic rng_s;
	logic [2:0] adr_s;

	// Edge detection on select and serial clock
	logic cs_prev_ff;
	logic sclk_prev_ff;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;

	// Frame control state
	aic_pkg::aic_state_t state_ff;
	aic_pkg::aic_state_t nxt_state;
	logic [3:0] rise_cnt_ff;
	logic [3:0] nxt_rise_cnt;
	logic [3:0] fall_cnt_ff;
	logic [3:0] nxt_fall_cnt;
	logic converting_ff;
	logic nxt_converting;
	logic tracking_ff;
	logic nxt_tracking;
	logic start_ff;
	logic nxt_start;
	logic restart_ff;
	logic nxt_restart;
	logic done_ff;
	logic nxt_done;

	// Selection sets: live, captured, and the two decoded views
	aic_pkg::aic_cfg_t live_ff;
	aic_pkg::aic_cfg_t nxt_live;
	aic_pkg::aic_cfg_t conv_ff;
	aic_pkg::aic_cfg_t nxt_conv;
	aic_pkg::aic_cfg_t now_cfg;
	aic_pkg::aic_cfg_t held_cfg;

	// Pin decode shared by the live view and the capture
	function automatic aic_pkg::aic_cfg_t aic_decode(
		input logic sgl,
		input logic [2:0] adr,
		input logic rng
	);
		aic_pkg::aic_cfg_t c;
		logic full;
		c = '0;
		full = 1'b0;
		if (sgl) begin
			// Six inputs against ground, same input on both converters
			c.mode = aic_pkg::AIC_SGL;
			if (adr <= 3'h5) begin
				c.pos_sel = adr + 3'h1;
			end else begin
				c.pos_sel = `AIC_SEL_NONE; // Unused codes select nothing
			end
			c.neg_sel = `AIC_SEL_NONE;
		end else begin
			// Three pairs; low bit picks full or pseudo
			c.mode = adr[0] ? aic_pkg::AIC_PSEUDO_DIFF : aic_pkg::AIC_FULL_DIFF;
			full = !adr[0];
			if (adr[2:1] != 2'h3) begin
				c.pos_sel = {adr[2:1], 1'b1};
				c.neg_sel = {adr[2:1], 1'b0} + 3'h2;
			end else begin
				c.pos_sel = `AIC_SEL_NONE;
				c.neg_sel = `AIC_SEL_NONE;
			end
		end
		c.range_dbl = rng;
		// Straight binary only for single or pseudo on single range
		c.twos_comp = rng | full;
		// Step weight doubles per double range and per full differential
		c.lsb_mult = `AIC_LSB_SINGLE << ({1'b0, rng} + {1'b0, full});
		return c;
	endfunction

	// Every pin, select and clock included, sees the same latency
	aic_sync #(.WIDTH(7)) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pin_i({cs_n_i, sclk_i, input_type_select_i, channel_address_bits_i, range_i}),
		.sync_o(pins)
	);
	assign {cs_n_s, sclk_s, sgl_s, adr_s, rng_s} = pins;

	// Edges against last cycle's synchronised level
	always_comb begin
		cs_fall = cs_prev_ff & ~cs_n_s;
		cs_rise = ~cs_prev_ff & cs_n_s;
		sclk_rise = ~sclk_prev_ff & sclk_s;
		sclk_fall = sclk_prev_ff & ~sclk_s;
	end

	// Reset low: synchroniser also resets low, so no false fall
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_prev_ff <= 1'b0;
			sclk_prev_ff <= 1'b0;
		end else begin
			cs_prev_ff <= cs_n_s;
			sclk_prev_ff <= sclk_s;
		end
	end

	// Frame sequencing, capture and coding choice
	always_comb begin
		now_cfg = aic_decode(sgl_s, adr_s, rng_s);
		held_cfg = aic_decode(sgl_s, adr_s, conv_ff.range_dbl);
		nxt_live = now_cfg;
		nxt_conv = conv_ff;
		nxt_state = state_ff;
		nxt_rise_cnt = rise_cnt_ff;
		nxt_fall_cnt = fall_cnt_ff;
		nxt_converting = converting_ff;
		nxt_tracking = tracking_ff;
		nxt_start = 1'b0;
		nxt_restart = 1'b0;
		nxt_done = 1'b0;
		case (state_ff)
			aic_pkg::AIC_ST_IDLE: begin
				if (cs_fall) begin
					// Sample both converters at the select fall
					nxt_state = aic_pkg::AIC_ST_HOLD;
					nxt_conv = now_cfg;
					nxt_rise_cnt = 4'h0;
					nxt_fall_cnt = 4'h0;
					nxt_converting = 1'b1;
					nxt_tracking = 1'b0;
					nxt_start = 1'b1;
				end
			end
			aic_pkg::AIC_ST_HOLD: begin
				if (cs_rise) begin
					// Cut frame: give up and go back to tracking
					nxt_state = aic_pkg::AIC_ST_IDLE;
					nxt_converting = 1'b0;
					nxt_tracking = 1'b1;
				end else begin
					if (sclk_fall) begin
						nxt_fall_cnt = fall_cnt_ff + 4'h1;
					end
					if (sclk_rise) begin
						nxt_rise_cnt = rise_cnt_ff + 4'h1;
						if (nxt_rise_cnt == `AIC_SCLK_TRACK_EDGE) begin
							nxt_tracking = 1'b1;
							nxt_state = aic_pkg::AIC_ST_TAIL;
						end
					end
					// Range may legally move late, so keep the captured range
					if (held_cfg.mode != conv_ff.mode) begin
						nxt_restart = 1'b1;
						nxt_conv = held_cfg;
					end
				end
			end
			aic_pkg::AIC_ST_TAIL: begin
				if (cs_rise) begin
					nxt_state = aic_pkg::AIC_ST_IDLE;
					nxt_converting = 1'b0;
				end else if (sclk_fall) begin
					nxt_fall_cnt = fall_cnt_ff + 4'h1;
					if (nxt_fall_cnt == `AIC_SCLK_DONE_EDGE) begin
						nxt_done = 1'b1;
						nxt_converting = 1'b0;
						nxt_state = aic_pkg::AIC_ST_IDLE;
					end
				end
			end
			default: begin
				nxt_state = aic_pkg::AIC_ST_IDLE;
			end
		endcase
	end

	// Register the frame and selection state
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= aic_pkg::AIC_ST_IDLE;
			rise_cnt_ff <= 4'h0;
			fall_cnt_ff <= 4'h0;
			converting_ff <= 1'b0;
			tracking_ff <= 1'b1;
			start_ff <= 1'b0;
			restart_ff <= 1'b0;
			done_ff <= 1'b0;
			live_ff <= '0;
			conv_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			rise_cnt_ff <= nxt_rise_cnt;
			fall_cnt_ff <= nxt_fall_cnt;
			converting_ff <= nxt_converting;
			tracking_ff <= nxt_tracking;
			start_ff <= nxt_start;
			restart_ff <= nxt_restart;
			done_ff <= nxt_done;
			live_ff <= nxt_live;
			conv_ff <= nxt_conv;
		end
	end

	// Outputs straight from flops
	assign live_cfg_o = live_ff;
	assign conv_cfg_o = conv_ff;
	assign converting_o = converting_ff;
	assign tracking_o = tracking_ff;
	assign conv_start_o = start_ff;
	assign acq_restart_o = restart_ff;
	assign conv_done_o = done_ff;

	// A fresh frame holds and converts
	sequence s_frame_open;
		converting_o && !tracking_o;
	endsequence

	frame_open_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		conv_start_o |-> s_frame_open) else $error("aic_core: frame not opened at start");
	capture_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		conv_start_o |-> conv_cfg_o == live_cfg_o) else $error("aic_core: capture differs");
	done_track_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		conv_done_o |-> tracking_o && !converting_o) else $error("aic_core: done while holding");
	restart_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		acq_restart_o |-> converting_o && !tracking_o) else $error("aic_core: restart outside hold");
	coding_choice_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		live_cfg_o.twos_comp == (live_cfg_o.range_dbl || live_cfg_o.mode == aic_pkg::AIC_FULL_DIFF))
		else $error("aic_core: coding choice wrong");
	single_ground_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		live_cfg_o.mode == aic_pkg::AIC_SGL |-> live_cfg_o.neg_sel == `AIC_SEL_NONE)
		else $error("aic_core: single-ended negative not ground");
	start_once_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		conv_start_o |=> !conv_start_o) else $error("aic_core: start pulse too long");
endmodule

/* aic_map.svh */
// Constants of the converter input configuration block
// Assumes inclusion by bare name from design files
`ifndef AIC_MAP_SVH
`define AIC_MAP_SVH
`define AIC_ADDR_W 3
`define AIC_SCLK_TRACK_EDGE 4'd13
`define AIC_SCLK_DONE_EDGE 4'd14
`define AIC_RANGE_FREE_FALL 4'd3
`define AIC_CODE_STEPS 13'h1000
`define AIC_SEL_NONE 3'h0
`define AIC_LSB_SINGLE 3'h1
`endif

/* aic_pkg.sv */
// Types of the converter input configuration block
// Assumes aic_map.svh holds the numeric constants
package aic_pkg;
	typedef enum logic [1:0] {AIC_SGL, AIC_FULL_DIFF, AIC_PSEUDO_DIFF} aic_mode_t;
	typedef enum logic [1:0] {AIC_ST_IDLE, AIC_ST_HOLD, AIC_ST_TAIL} aic_state_t;
	typedef struct packed {
		aic_mode_t mode;
		logic [2:0] pos_sel;
		logic [2:0] neg_sel;
		logic twos_comp;
		logic range_dbl;
		logic [2:0] lsb_mult;
	} aic_cfg_t;
endpackage

/* aic_sync.sv */
// Three-stage pin synchroniser, second and third stage agreement
// Assumes asynchronous pins and one clock
`timescale 1ns/10ps
`include "aic_map.svh"
module aic_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Pins
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, sync_ff;
	logic [WIDTH-1:0] nxt_sync;
	// Accept a change only once two late stages agree
	always_comb begin
		nxt_sync = sync_ff;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_sync[i] = s3_ff[i];
			end
		end
	end
	// First stage feeds only the second
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			sync_ff <= '0;
		end else begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			sync_ff <= nxt_sync;
		end
	end
	assign sync_o = sync_ff;
endmodule

/* aic_host.sv */
// Host model: chip select and fourteen-cycle serial clock frames
// Assumes go_i pulses only while no frame runs
`timescale 1ns/10ps
module aic_host (
	// Start
	input wire logic go_i,
	// Pins
	output logic cs_n_o,
	output logic sclk_o
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b1;
	end
	// Whole frame, clock idles high between frames
	always @(posedge go_i) begin
		cs_n_o = 1'b0;
		repeat (28) #16 sclk_o = ~sclk_o;
		#16 cs_n_o = 1'b1;
	end
endmodule

/* tb_top.sv */
// Bench of the input configuration block
// Assumes the host model makes select and serial clock
`timescale 1ns/10ps
module tb_top;
	logic clk_i = 0, rst_n_i = 0, go = 0, typ = 1, rng = 0, cs_n, sclk, cv, trk, st, rs, dn;
	logic [2:0] adr = 3'h0;
	logic [1:0] m;
	aic_pkg::aic_cfg_t live, conv;
	int bad_count = 0, n_tests = 0;
	initial forever #2 clk_i = ~clk_i;
	aic_host host (.go_i(go), .cs_n_o(cs_n), .sclk_o(sclk));
	aic_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.input_type_select_i(typ), .channel_address_bits_i(adr), .range_i(rng),
		.live_cfg_o(live), .conv_cfg_o(conv), .converting_o(cv), .tracking_o(trk),
		.conv_start_o(st), .acq_restart_o(rs), .conv_done_o(dn));
	// Compare and count
	task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Both types, addresses 0 to 5 and both ranges; pins settle through the synchroniser
	task automatic t_sel;
		for (int k = 0; k < 24; k++) begin
			@(negedge clk_i);
			typ = (k % 12) < 6;
			adr = 3'(k % 6);
			rng = k >= 12;
			repeat (10) @(negedge clk_i);
			m = typ ? 2'h0 : (adr[0] ? 2'h2 : 2'h1);
			chk("cfg", {m, typ ? adr + 3'h1 : {adr[2:1], 1'b1}, typ ? 3'h0 : {adr[2:1], 1'b0} + 3'h2,
				rng | (m == 2'h1), rng}, live[12:3]);
			chk("lsb", {7'h0, 3'h1 << ({1'b0, rng} + {1'b0, m == 2'h1})}, {7'h0, live.lsb_mult});
		end
		$display("Test sel done");
	endtask
	// Captured set survives a range change after the third falling edge
	task automatic t_conv;
		typ = 0;
		adr = 3'h0;
		rng = 1;
		repeat (10) @(negedge clk_i);
		go = 1;
		for (int w = 0; w < 40 && st !== 1'b1; w++) @(negedge clk_i);
		chk("start", 10'h6, {7'h0, st, cv, trk});
		repeat (28) @(negedge clk_i);
		rng = 0;
		for (int w = 0; w < 300 && dn !== 1'b1; w++) @(negedge clk_i);
		chk("done", 10'h6, {7'h0, dn, trk, cv});
		chk("conv", {2'h1, 3'h1, 3'h2, 2'h3}, conv[12:3]);
		chk("conv lsb", 10'h4, {7'h0, conv.lsb_mult});
		go = 0;
		$display("Test conv done");
	endtask
	// Address change that alters the mode mid-conversion
	task automatic t_restart;
		repeat (20) @(negedge clk_i);
		typ = 0;
		adr = 3'h2;
		rng = 0;
		repeat (10) @(negedge clk_i);
		go = 1;
		for (int w = 0; w < 40 && st !== 1'b1; w++) @(negedge clk_i);
		adr = 3'h3;
		for (int w = 0; w < 20 && rs !== 1'b1; w++) @(negedge clk_i);
		chk("restart", 10'h3, {8'h0, rs, cv});
		chk("recapture", {2'h2, 3'h3, 3'h4, 2'h0}, conv[12:3]);
		for (int w = 0; w < 300 && dn !== 1'b1; w++) @(negedge clk_i);
		chk("restart done", 10'h1, {9'h0, dn});
		go = 0;
		$display("Test restart done");
	endtask
	task automatic summarize;
		$display("Comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#30000;
		bad_count++;
		summarize;
	end
	initial begin
		repeat (5) @(negedge clk_i);
		rst_n_i = 1;
		t_sel;
		t_conv;
		t_restart;
		summarize;
	end
endmodule
